//--- core/bbrtc_top.sv
// Purpose: Byte-wide nonvolatile memory with a double-buffered timekeeper on top.
// Assumes: Bus pins are synchronous to mclk; supply_ok reports a good supply.
// Notes: Read data and its enable appear one mclk after the request is seen.
// Function
// - The host reads and writes a 32768 by 8-bit byte array over the parallel bus.
// - The eight highest addresses hold the timekeeper registers instead of plain memory.
// - Time registers keep year, month, date, day, hours, minutes and seconds in BCD, 24-hour.
// - The date rolls over by month length and leap year automatically.
// - Time is double-buffered, so host access never disturbs the running counters.
// - Setting the read-halt bit (bit 6 of control) stops copies into the visible registers.
// - While halted the visible registers keep the time captured at the halt.
// - After read-halt clears, all visible registers refresh together within a second.
// - Setting the write-halt bit (bit 7) stops updates so the host can load new time.
// - Clearing write-halt copies the loaded time into the counters, which count on from there.
// - With the supply out of tolerance the device ignores all access and floats data.
// - Chip-select low with write strobe high is a read of the addressed byte.
// - Chip-select and write strobe both low is a write, starting at the later fall.
// - Data pins drive only when chip-select and output-enable are low during a read.
`timescale 1ns/1ps
`include "bbrtc_map.svh"

module bbrtc_top #(
    parameter int TICK_CYCLES = `BBRTC_TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Supply monitor
    input wire logic supply_ok,
    // Memory bus strobes
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    // Address
    input wire logic [`BBRTC_ADDR_W-1:0] addr_pins,
    // Data pins
    input wire logic [7:0] byte_lane_pins_in,
    output logic [7:0] byte_lane_pins_out,
    output logic byte_lane_pins_oe_n
);

    typedef struct packed {
        bbrtc_pkg::bbrtc_mode_e mode;
        logic ctrl_w;
        logic ctrl_r;
        bbrtc_pkg::bbrtc_time_s user;
        logic [27:0] tick_cnt;
        logic tick;
        logic tick_d;
        logic load_pend;
        logic [7:0] dout;
        logic oe_n;
    } bbrtc_top_s;

    localparam logic [27:0] TICK_LAST = 28'(TICK_CYCLES - 1);

    bbrtc_top_s st;
    bbrtc_top_s next_st;
    bbrtc_pkg::bbrtc_time_s cal_time;
    bbrtc_pkg::bbrtc_mode_e mode;
    logic rtc_hit;
    logic ram_wr;
    logic [7:0] ram_rdata;
    logic [7:0] rtc_rdata;
    logic [7:0] din;

    assign din = byte_lane_pins_in;
    assign rtc_hit = (addr_pins[14:3] == `BBRTC_RTC_BASE);
    assign ram_wr = (mode == bbrtc_pkg::MODE_WRITE) && !rtc_hit;

    // Power-fail deselect overrides every strobe
    always_comb begin
        if (!supply_ok || chip_sel_n) begin
            mode = bbrtc_pkg::MODE_DESELECT;
        end else if (!write_en_n) begin
            mode = bbrtc_pkg::MODE_WRITE;
        end else begin
            mode = bbrtc_pkg::MODE_READ;
        end
    end

    always_comb begin
        case (addr_pins[2:0])
            `BBRTC_ADDR_CTRL: rtc_rdata = {st.ctrl_w, st.ctrl_r, 6'h00};
            `BBRTC_ADDR_SEC: rtc_rdata = st.user.sec;
            `BBRTC_ADDR_MIN: rtc_rdata = st.user.min;
            `BBRTC_ADDR_HOUR: rtc_rdata = st.user.hour;
            `BBRTC_ADDR_DAY: rtc_rdata = st.user.day;
            `BBRTC_ADDR_DATE: rtc_rdata = st.user.date;
            `BBRTC_ADDR_MONTH: rtc_rdata = st.user.month;
            default: rtc_rdata = st.user.year;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.mode = mode;
        // Free-running second divider; it never stops, so timekeeping is not lost
        if (st.tick_cnt >= TICK_LAST) begin
            next_st.tick_cnt = 28'h0000000;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 28'h0000001;
            next_st.tick = 1'b0;
        end
        next_st.tick_d = st.tick;
        // Copy one cycle after the counters advanced, all fields at once
        if (st.tick_d && !st.ctrl_r && !st.ctrl_w) begin
            next_st.user = cal_time;
        end
        case (mode)
            bbrtc_pkg::MODE_WRITE: begin
                if (rtc_hit) begin
                    case (addr_pins[2:0])
                        `BBRTC_ADDR_CTRL: begin
                            next_st.ctrl_w = din[`BBRTC_CTRL_WHALT];
                            next_st.ctrl_r = din[`BBRTC_CTRL_RHALT];
                        end
                        `BBRTC_ADDR_SEC: next_st.user.sec = din & `BBRTC_MASK_SEC;
                        `BBRTC_ADDR_MIN: next_st.user.min = din & `BBRTC_MASK_MIN;
                        `BBRTC_ADDR_HOUR: next_st.user.hour = din & `BBRTC_MASK_HOUR;
                        `BBRTC_ADDR_DAY: next_st.user.day = din & `BBRTC_MASK_DAY;
                        `BBRTC_ADDR_DATE: next_st.user.date = din & `BBRTC_MASK_DATE;
                        `BBRTC_ADDR_MONTH: next_st.user.month = din & `BBRTC_MASK_MONTH;
                        default: next_st.user.year = din & `BBRTC_MASK_YEAR;
                    endcase
                end
                next_st.oe_n = 1'b1;
            end
            bbrtc_pkg::MODE_READ: begin
                next_st.dout = rtc_hit ? rtc_rdata : ram_rdata;
                next_st.oe_n = out_en_n;
            end
            default: begin
                next_st.oe_n = 1'b1;
            end
        endcase
        // Load pulse on the falling edge of write-halt
        next_st.load_pend = st.ctrl_w && !next_st.ctrl_w;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st <= '0;
            st.mode <= bbrtc_pkg::MODE_DESELECT;
            st.user.day <= `BBRTC_RST_DAY;
            st.user.date <= `BBRTC_RST_DATE;
            st.user.month <= `BBRTC_RST_MONTH;
            st.oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    bbrtc_array u_array (
        .mclk(mclk),
        .wr_en(ram_wr),
        .index(addr_pins),
        .wdata(din),
        .rdata(ram_rdata)
    );

    bbrtc_calendar u_calendar (
        .mclk(mclk),
        .reset(reset),
        .tick(st.tick),
        .load(st.load_pend),
        .load_time(st.user),
        .cal_time(cal_time)
    );

    assign byte_lane_pins_out = st.dout;
    assign byte_lane_pins_oe_n = st.oe_n;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_deselect_float: assert property (!supply_ok |=> byte_lane_pins_oe_n)
        else $error("data driven while supply out of tolerance");

    a_read_drive: assert property (supply_ok && !chip_sel_n && !out_en_n && write_en_n
        |=> !byte_lane_pins_oe_n)
        else $error("read with output enable did not drive data");

    a_write_float: assert property (!write_en_n |=> byte_lane_pins_oe_n)
        else $error("data driven during write strobe");

    a_halt_hold: assert property (st.ctrl_r && mode != bbrtc_pkg::MODE_WRITE
        |=> $stable(st.user))
        else $error("visible time changed while read-halted");

    a_tick_refresh: assert property (st.tick_d && !st.ctrl_r && !st.ctrl_w
        && mode != bbrtc_pkg::MODE_WRITE |=> st.user == $past(cal_time))
        else $error("visible time not refreshed on second tick");

    a_load_flag: assert property ($fell(st.ctrl_w) |-> st.load_pend)
        else $error("clearing write-halt did not raise load");

    a_load_copy: assert property (st.load_pend |=> cal_time == $past(st.user))
        else $error("counters did not take loaded time");

    a_load_once: assert property (st.load_pend |=> !st.load_pend)
        else $error("load pulse longer than one cycle");

    a_read_ram: assert property (mode == bbrtc_pkg::MODE_READ && !rtc_hit
        |=> byte_lane_pins_out == $past(ram_rdata))
        else $error("memory read returned wrong byte");

    a_time_write: assert property (mode == bbrtc_pkg::MODE_WRITE && rtc_hit
        && addr_pins[2:0] == `BBRTC_ADDR_MIN && !st.tick_d
        |=> st.user.min == ($past(din) & `BBRTC_MASK_MIN))
        else $error("minutes write not stored");

    // Last second of a day; checker use only
    logic day_end;
    assign day_end = st.tick && !st.load_pend && cal_time.hour == 8'h23
        && cal_time.min == 8'h59 && cal_time.sec == 8'h59;

    a_mode_float: assert property (st.mode != bbrtc_pkg::MODE_READ
        |-> byte_lane_pins_oe_n)
        else $error("data driven outside a read");

    a_oe_follow: assert property (st.mode == bbrtc_pkg::MODE_READ
        |-> byte_lane_pins_oe_n == $past(out_en_n))
        else $error("read drive does not follow output enable");

    a_dout_hold: assert property (mode != bbrtc_pkg::MODE_READ
        |=> $stable(byte_lane_pins_out))
        else $error("read data changed outside a read");

    a_tick_period: assert property (st.tick_cnt == TICK_LAST |=> st.tick)
        else $error("second tick missed");

    a_tick_clear: assert property (st.tick |-> st.tick_cnt == 28'h0000000)
        else $error("divider not restarted with tick");

    a_rhalt_take: assert property (mode == bbrtc_pkg::MODE_WRITE && rtc_hit
        && addr_pins[2:0] == `BBRTC_ADDR_CTRL
        |=> st.ctrl_r == $past(din[`BBRTC_CTRL_RHALT]))
        else $error("read-halt bit not stored");

    a_whalt_take: assert property (mode == bbrtc_pkg::MODE_WRITE && rtc_hit
        && addr_pins[2:0] == `BBRTC_ADDR_CTRL
        |=> st.ctrl_w == $past(din[`BBRTC_CTRL_WHALT]))
        else $error("write-halt bit not stored");

    a_whalt_hold: assert property (st.ctrl_w && mode != bbrtc_pkg::MODE_WRITE
        |=> $stable(st.user))
        else $error("visible time changed while write-halted");

    a_supply_lock: assert property (!supply_ok
        |=> $stable({st.ctrl_w, st.ctrl_r}))
        else $error("control changed while supply out of tolerance");

    a_ctrl_read: assert property (mode == bbrtc_pkg::MODE_READ && rtc_hit
        && addr_pins[2:0] == `BBRTC_ADDR_CTRL
        |=> byte_lane_pins_out == {$past(st.ctrl_w), $past(st.ctrl_r), 6'h00})
        else $error("control read returned wrong byte");

    a_sec_read: assert property (mode == bbrtc_pkg::MODE_READ && rtc_hit
        && addr_pins[2:0] == `BBRTC_ADDR_SEC
        |=> byte_lane_pins_out == $past(st.user.sec))
        else $error("seconds read returned wrong byte");

    a_count_on: assert property (st.tick && !st.load_pend
        |=> cal_time.sec != $past(cal_time.sec))
        else $error("counters stood still on a tick");

    a_user_still: assert property (!st.tick_d && mode != bbrtc_pkg::MODE_WRITE
        |=> $stable(st.user))
        else $error("visible time changed off a refresh");

    a_sec_wrap: assert property (st.tick && !st.load_pend && cal_time.sec == 8'h59
        |=> cal_time.sec == 8'h00)
        else $error("seconds did not wrap");

    a_min_wrap: assert property (st.tick && !st.load_pend && cal_time.sec == 8'h59
        && cal_time.min == 8'h59 |=> cal_time.min == 8'h00)
        else $error("minutes did not wrap");

    a_day_wrap: assert property (day_end
        |=> cal_time.hour == 8'h00 && cal_time.min == 8'h00 && cal_time.sec == 8'h00)
        else $error("time of day did not wrap at 24 hours");

    a_week_wrap: assert property (day_end && cal_time.day == 8'h07
        |=> cal_time.day == 8'h01)
        else $error("day of week did not wrap");

    a_leap_feb: assert property (day_end && cal_time.month == 8'h02
        && cal_time.date == 8'h28 && cal_time.year == 8'h00
        |=> cal_time.date == 8'h29 && cal_time.month == 8'h02)
        else $error("leap year lost its last day of february");

    a_plain_feb: assert property (day_end && cal_time.month == 8'h02
        && cal_time.date == 8'h28 && cal_time.year == 8'h01
        |=> cal_time.date == 8'h01 && cal_time.month == 8'h03)
        else $error("common year did not roll into march");

endmodule

//--- core/bbrtc_map.svh
// Purpose: Addresses, field masks, reset values and timing counts of the timekeeper.
// Assumes: 15-bit byte address and an 8-bit data path.
// Notes: Included by bare name wherever these constants are needed.
`ifndef BBRTC_MAP_SVH
`define BBRTC_MAP_SVH

`define BBRTC_ADDR_W 15
`define BBRTC_DEPTH 32768
`define BBRTC_RTC_BASE 12'hfff
`define BBRTC_ADDR_CTRL 3'h0
`define BBRTC_ADDR_SEC 3'h1
`define BBRTC_ADDR_MIN 3'h2
`define BBRTC_ADDR_HOUR 3'h3
`define BBRTC_ADDR_DAY 3'h4
`define BBRTC_ADDR_DATE 3'h5
`define BBRTC_ADDR_MONTH 3'h6
`define BBRTC_ADDR_YEAR 3'h7

`define BBRTC_CTRL_WHALT 7
`define BBRTC_CTRL_RHALT 6

`define BBRTC_MASK_SEC 8'h7f
`define BBRTC_MASK_MIN 8'h7f
`define BBRTC_MASK_HOUR 8'h3f
`define BBRTC_MASK_DAY 8'h07
`define BBRTC_MASK_DATE 8'h3f
`define BBRTC_MASK_MONTH 8'h1f
`define BBRTC_MASK_YEAR 8'hff

`define BBRTC_RST_TIME 8'h00
`define BBRTC_RST_DAY 8'h01
`define BBRTC_RST_DATE 8'h01
`define BBRTC_RST_MONTH 8'h01

`define BBRTC_CLK_PERIOD_NS 5
`define BBRTC_TICK_NS 1000000000
`define BBRTC_TICK_CYCLES (`BBRTC_TICK_NS / `BBRTC_CLK_PERIOD_NS)

`endif

//--- core/bbrtc_pkg.sv
// Purpose: Types shared by the timekeeper modules.
// Assumes: Nothing beyond the map header.
// Notes: Time fields are BCD bytes.
package bbrtc_pkg;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } bbrtc_time_s;

    typedef enum logic [1:0] {
        MODE_DESELECT,
        MODE_READ,
        MODE_WRITE
    } bbrtc_mode_e;

endpackage

//--- core/bbrtc_array.sv
// Purpose: Plain byte storage below the timekeeper locations.
// Assumes: Address and strobe already qualified by the caller.
// Notes: Read is combinational from the storage flops; caller registers it.
`timescale 1ns/1ps
`include "bbrtc_map.svh"

module bbrtc_array (
    // Clock
    input wire logic mclk,
    // Access
    input wire logic wr_en,
    input wire logic [`BBRTC_ADDR_W-1:0] index,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);

    // Contents are nonvolatile, so reset leaves them alone
    logic [7:0] mem [0:`BBRTC_DEPTH-1];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[index] <= wdata;
        end
    end

    assign rdata = mem[index];

endmodule

//--- core/bbrtc_calendar.sv
// Purpose: Internal BCD time and calendar counters.
// Assumes: tick is a one-cycle pulse once per second.
// Notes: A load takes priority over a tick in the same cycle.
`timescale 1ns/1ps
`include "bbrtc_map.svh"

module bbrtc_calendar (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Control
    input wire logic tick,
    input wire logic load,
    input wire bbrtc_pkg::bbrtc_time_s load_time,
    // Counters
    output bbrtc_pkg::bbrtc_time_s cal_time
);

    bbrtc_pkg::bbrtc_time_s st;
    bbrtc_pkg::bbrtc_time_s next_st;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = v + 8'h01;
        end
    endfunction

    // Two-digit year, so 00 counts as leap
    function automatic logic is_leap(input logic [7:0] y);
        if (y[4]) begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
    endfunction

    function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02: last_date = is_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
            default: last_date = 8'h31;
        endcase
    endfunction

    always_comb begin
        next_st = st;
        if (load) begin
            next_st = load_time;
        end else if (tick) begin
            next_st.sec = bcd_inc(st.sec);
            if (st.sec == 8'h59) begin
                next_st.sec = 8'h00;
                next_st.min = bcd_inc(st.min);
                if (st.min == 8'h59) begin
                    next_st.min = 8'h00;
                    next_st.hour = bcd_inc(st.hour);
                    if (st.hour == 8'h23) begin
                        next_st.hour = 8'h00;
                        next_st.day = (st.day == 8'h07) ? 8'h01 : bcd_inc(st.day);
                        next_st.date = bcd_inc(st.date);
                        if (st.date >= last_date(st.month, st.year)) begin
                            next_st.date = 8'h01;
                            next_st.month = bcd_inc(st.month);
                            if (st.month >= 8'h12) begin
                                next_st.month = 8'h01;
                                next_st.year = (st.year == 8'h99) ? 8'h00 : bcd_inc(st.year);
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st <= '{year: `BBRTC_RST_TIME, month: `BBRTC_RST_MONTH, date: `BBRTC_RST_DATE,
                    day: `BBRTC_RST_DAY, hour: `BBRTC_RST_TIME, min: `BBRTC_RST_TIME,
                    sec: `BBRTC_RST_TIME};
        end else begin
            st <= next_st;
        end
    end

    assign cal_time = st;

endmodule

//--- tb/bbrtc_host.sv
// Purpose: Host model on the byte-wide asynchronous memory bus.
// Assumes: Device samples the strobes on the rising mclk edge.
// Notes: An idle data bus shows the inverse of the last byte, never a held value.
`timescale 1ns/1ps
`include "bbrtc_map.svh"

module bbrtc_host (
    // Clock
    input wire logic mclk,
    // Device data driver
    input wire logic [7:0] dev_out,
    input wire logic dev_oe_n,
    // Strobes
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_en_n,
    // Address and wire level
    output logic [`BBRTC_ADDR_W-1:0] addr_pins,
    output logic [7:0] pins_in
);
    logic drive = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] last = 8'h00;

    assign pins_in = !dev_oe_n ? dev_out : (drive ? wdata : ~last);

    initial begin
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        write_en_n = 1'b1;
        addr_pins = '0;
    end

    task automatic write_byte(input logic [14:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr_pins <= a;
        wdata <= d;
        drive <= 1'b1;
        chip_sel_n <= 1'b0;
        write_en_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chip_sel_n <= 1'b1;
        write_en_n <= 1'b1;
        drive <= 1'b0;
        last <= d;
    endtask

    task automatic read_byte(input logic [14:0] a, input logic oe, output logic [7:0] d,
                             output logic oen);
        @(posedge mclk);
        addr_pins <= a;
        chip_sel_n <= 1'b0;
        out_en_n <= !oe;
        repeat (2) @(posedge mclk);
        #1;
        d = pins_in;
        oen = dev_oe_n;
        @(posedge mclk);
        chip_sel_n <= 1'b1;
        out_en_n <= 1'b1;
    endtask
endmodule

//--- tb/bbrtc_top_tb_top.sv
// Purpose: Self-checking bench for the memory and timekeeper.
// Assumes: TICK_CYCLES shortened to 20 so a second is 20 mclk.
// Notes: Time reads in the rollover loop are done under read-halt so fields never tear.
`timescale 1ns/1ps
`include "bbrtc_map.svh"

module bbrtc_top_tb_top;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic supply_ok = 1'b1;
    logic chip_sel_n;
    logic out_en_n;
    logic write_en_n;
    logic [14:0] addr_pins;
    logic [7:0] pins_in;
    logic [7:0] dout;
    logic oe_n;
    int fail_count = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h00010b3f;
    logic [14:0] ma [12];
    logic [7:0] md [12];
    logic [7:0] tv [1:7];
    logic [7:0] ev [1:7];
    logic [7:0] d;
    logic [7:0] d2;
    logic oen;

    always #2.5 mclk = ~mclk;

    bbrtc_top #(.TICK_CYCLES(20)) dut (.mclk(mclk), .reset(reset), .supply_ok(supply_ok),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .addr_pins(addr_pins), .byte_lane_pins_in(pins_in), .byte_lane_pins_out(dout),
        .byte_lane_pins_oe_n(oe_n));

    bbrtc_host h (.mclk(mclk), .dev_out(dout), .dev_oe_n(oe_n), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_en_n(write_en_n), .addr_pins(addr_pins),
        .pins_in(pins_in));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [14:0] rtc(input int o);
        return {`BBRTC_RTC_BASE, o[2:0]};
    endfunction

    // Two-digit year, 00 counts as leap
    function automatic logic leap(input logic [7:0] y);
        return ((y[7:4] * 10 + y[3:0]) % 4) == 0;
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [14:0] a, input logic [7:0] exp, input string what);
        h.read_byte(a, 1'b1, d, oen);
        check({what, " oe_n"}, {7'h0, oen}, 8'h00);
        check(what, d, exp);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #50000;
        fail_count++;
        $display("MISMATCH watchdog expired");
        complete_run();
    end

    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        rd(rtc(0), 8'h00, "ctrl");
        rd(rtc(5), 8'h01, "date");
        rd(rtc(6), 8'h01, "month");
        // Edge addresses first, then random plain memory
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            // Index in the top nibble keeps random addresses apart
            ma[i] = (i == 0) ? 15'h7ff7 : (i == 1) ? 15'h0000 : {4'(i), seed[10:0]};
            md[i] = seed[22:15];
            h.write_byte(ma[i], md[i]);
        end
        for (int i = 0; i < 12; i++) rd(ma[i], md[i], "mem");
        h.read_byte(ma[2], 1'b0, d, oen);
        check("oe_n out_en high", {7'h0, oen}, 8'h01);
        supply_ok <= 1'b0;
        h.write_byte(ma[3], ~md[3]);
        h.read_byte(ma[3], 1'b1, d, oen);
        check("oe_n supply low", {7'h0, oen}, 8'h01);
        supply_ok <= 1'b1;
        rd(ma[3], md[3], "mem after fail");
        for (int k = 0; k < 2; k++) begin
            tv = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'(k)};
            ev = '{8'h00, 8'h00, 8'h00, 8'h01, leap(tv[7]) ? 8'h29 : 8'h01,
                   leap(tv[7]) ? 8'h02 : 8'h03, tv[7]};
            h.write_byte(rtc(0), 8'hc0);
            for (int j = 1; j < 8; j++) h.write_byte(rtc(j), tv[j]);
            h.write_byte(rtc(0), 8'h40);
            repeat (50) @(posedge mclk);
            for (int j = 1; j < 8; j++) rd(rtc(j), tv[j], "frozen");
            rd(rtc(0), 8'h40, "ctrl");
            h.write_byte(rtc(0), 8'h00);
            repeat (25) @(posedge mclk);
            h.write_byte(rtc(0), 8'h40);
            h.read_byte(rtc(1), 1'b1, d, oen);
            check("sec tens", {4'h0, d[7:4]}, 8'h00);
            for (int j = 2; j < 8; j++) rd(rtc(j), ev[j], "rolled");
            h.write_byte(rtc(0), 8'h00);
        end
        h.read_byte(rtc(1), 1'b1, d, oen);
        repeat (25) @(posedge mclk);
        h.read_byte(rtc(1), 1'b1, d2, oen);
        check("sec moves", {7'h0, d2 != d}, 8'h01);
        complete_run();
    end
endmodule
